// [hw/baud_gen_pkg.sv]
package baud_gen_pkg;

    // ========================================
    // bus and register map
    localparam int         AXI_ADDR_W          = 8;
    localparam logic [7:0] RATE_SELECT_OFFSET  = 8'h00;
    localparam logic [7:0] FINE_PRESCALE_OFFSET = 8'h04;
    localparam logic [7:0] RATE_STATUS_OFFSET  = 8'h08;
    localparam logic [1:0] RESP_OKAY           = 2'h0;
    localparam logic [1:0] RESP_SLVERR         = 2'h2;

    // ========================================
    // field positions and reset values
    localparam int         LIN_TX_BIT          = 7;
    localparam int         LIN_RX_BIT          = 6;
    localparam int         PRESCALE_LSB        = 4;
    localparam int         RATE_LSB            = 0;
    localparam int         INT_PRESCALE_LSB    = 5;
    localparam int         FINE_LSB            = 0;
    localparam int         STATUS_TX_LSB       = 4;
    localparam int         STATUS_FRAME_LSB    = 8;
    localparam int         STATUS_BYPASS_BIT   = 16;
    localparam logic [7:0] RATE_SELECT_MASK    = 8'hF7;
    localparam logic [7:0] RATE_SELECT_RESET   = 8'h00;
    localparam logic [7:0] FINE_PRESCALE_RESET = 8'h00;

    // ========================================
    // cycle and bit counts
    localparam int         OVERSAMPLE_DIV      = 4;
    localparam logic [3:0] SAMPLES_LAST        = 4'hF;
    localparam logic [3:0] BREAK_NORMAL_SHORT  = 4'hA;
    localparam logic [3:0] BREAK_NORMAL_LONG   = 4'hB;
    localparam logic [3:0] BREAK_LIN_SHORT     = 4'hB;
    localparam logic [3:0] BREAK_LIN_LONG      = 4'hC;

    // ========================================
    // decoders
    function automatic logic [3:0] prescale_divisor(input logic [1:0] code);
        case (code)
            2'h0:    return 4'h1;
            2'h1:    return 4'h3;
            2'h2:    return 4'h4;
            default: return 4'hD;
        endcase
    endfunction

    function automatic logic [7:0] rate_divisor(input logic [2:0] code);
        return 8'h01 << code;
    endfunction

    function automatic logic [3:0] int_divisor(input logic [2:0] code);
        return {1'b0, code} + 4'h1;
    endfunction

    function automatic logic [12:0] rt_limit(input logic [7:0] rs);
        logic [13:0] p;
        p = 14'(prescale_divisor(rs[PRESCALE_LSB+:2]))
            * 14'(rate_divisor(rs[RATE_LSB+:3])) * 14'(OVERSAMPLE_DIV);
        return 13'(p - 14'h1);
    endfunction

    function automatic logic [3:0] break_bits(input logic lin,
                                              input logic long_char);
        if (lin) begin
            return long_char ? BREAK_LIN_LONG : BREAK_LIN_SHORT;
        end
        return long_char ? BREAK_NORMAL_LONG : BREAK_NORMAL_SHORT;
    endfunction

endpackage

// [hw/frac_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module frac_prescaler (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       run,
    input  wire logic       src_tick,
    input  wire logic [2:0] int_code,
    input  wire logic [4:0] fine_code,
    output logic            tick,
    output logic [4:0]      frame_pos,
    output logic            bypass
);
    import baud_gen_pkg::*;

    typedef struct packed {
        logic [3:0] count;
        logic [4:0] acc;
        logic [4:0] frame;
        logic       tick;
    } state_s;

    state_s     st;
    state_s     next_st;
    logic [5:0] acc_sum;
    logic [3:0] int_div;

    assign bypass    = (int_code == 3'h0);
    assign int_div   = int_divisor(int_code);
    assign acc_sum   = {1'b0, st.acc} + {1'b0, fine_code};
    assign tick      = st.tick;
    assign frame_pos = st.frame;

    // ========================================
    // prescaler with clock insertion
    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        if (!run) begin
            next_st = '0;
        end else if (src_tick) begin
            if (bypass) begin
                next_st.tick = 1'b1;
                next_st.count = 4'h0;
                next_st.acc = 5'h00;
            end else if (st.count >= int_div - 4'h1 + {3'h0, acc_sum[5]}) begin
                // carry stretches this period: spreads evenly
                next_st.tick = 1'b1;
                next_st.count = 4'h0;
                next_st.frame = st.frame + 5'h01;
                next_st.acc = (st.frame == 5'h1F) ? 5'h00 : acc_sum[4:0];
            end else begin
                next_st.count = st.count + 4'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // checks
    logic [4:0] gap;
    logic [5:0] ins;
    logic       frame_ok;
    logic       stretched;
    assign stretched = (gap == int_div + 4'h1);
    always_ff @(posedge aclk) begin
        if (!aresetn || !run || bypass || $changed(fine_code)
            || $changed(int_code)) begin
            gap <= '0;
            ins <= '0;
            frame_ok <= 1'b0;
        end else begin
            gap <= (tick ? 5'h00 : gap) + {4'h0, src_tick};
            if (tick) begin
                ins <= (st.frame == 5'h00) ? 6'h00
                       : ins + {5'h0, stretched};
                frame_ok <= frame_ok || (st.frame == 5'h00);
            end
        end
    end

    a_bypass_follow: assert property (@(posedge aclk)
        disable iff (!aresetn)
        run && bypass && src_tick |=> tick)
        else $error("bypass did not pass source tick");
    a_period_bounds: assert property (@(posedge aclk)
        disable iff (!aresetn)
        tick && frame_ok && !bypass && run |-> gap == int_div || stretched)
        else $error("prescaler period out of range");
    a_frame_inserts: assert property (@(posedge aclk)
        disable iff (!aresetn)
        tick && frame_ok && run && !bypass && st.frame == 5'h00
        |-> ins + {5'h0, stretched} == {1'b0, fine_code})
        else $error("wrong insert count in frame");
endmodule
`default_nettype wire

// [hw/lin_baud_rate_generator.sv]
// Behaviour
// - rx-only LIN: break detect 11/12 bits
// - tx-only LIN: break generate 11/12 bits
// - both LIN: both 11/12; none: normal
// - register prescale 00..11 -> 1,3,4,13
// - rate divide code n -> two^n
// - integer prescale 000 bypass, else code+1
// - bypass code also skips fine adjust
// - fine code N: N inserts per 32
// - rate: source over 64*prescale*rate*(int+N/32)
// - source is bus or crystal clock
// - one divided clock for rx and tx
// - reset clears all options and codes
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module lin_baud_rate_generator (
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    input  wire logic [baud_gen_pkg::AXI_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                         awprot,
    input  wire logic                               awvalid,
    output logic                                    awready,
    input  wire logic [31:0]                        wdata,
    input  wire logic [3:0]                         wstrb,
    input  wire logic                               wvalid,
    output logic                                    wready,
    output logic [1:0]                              bresp,
    output logic                                    bvalid,
    input  wire logic                               bready,
    input  wire logic [baud_gen_pkg::AXI_ADDR_W-1:0] araddr,
    input  wire logic [2:0]                         arprot,
    input  wire logic                               arvalid,
    output logic                                    arready,
    output logic [31:0]                             rdata,
    output logic [1:0]                              rresp,
    output logic                                    rvalid,
    input  wire logic                               rready,
    input  wire logic                               crystal_clock,
    input  wire logic                               rate_clock_source_select,
    input  wire logic                               serial_enable,
    input  wire logic                               char_length_select,
    output logic                                    sample_tick,
    output logic                                    bit_tick,
    output logic [3:0]                              rx_break_bits,
    output logic [3:0]                              tx_break_bits
);
    import baud_gen_pkg::*;

    // ========================================
    // state
    typedef struct packed {
        logic [7:0]            rate_select;
        logic [7:0]            fine_prescale;
        logic                  aw_held;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic                  w_held;
        logic [7:0]            w_data;
        logic                  w_strb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic [1:0]            xtal_sync;
        logic                  xtal_prev;
        logic [12:0]           rt_count;
        logic [3:0]            bit_count;
        logic                  sample_tick;
        logic                  bit_tick;
        logic [3:0]            rx_break_bits;
        logic [3:0]            tx_break_bits;
    } state_s;

    localparam state_s RESET_STATE = '{
        rate_select:   RATE_SELECT_RESET,
        fine_prescale: FINE_PRESCALE_RESET,
        rx_break_bits: BREAK_NORMAL_SHORT,
        tx_break_bits: BREAK_NORMAL_SHORT,
        default:       '0
    };

    state_s      st;
    state_s      next_st;
    logic        src_tick;
    logic        pre_tick;
    logic        bypass;
    logic [4:0]  frame_pos;
    logic        lin_tx_break_option;
    logic        lin_rx_break_option;
    logic [12:0] limit;
    logic [31:0] status_word;

    assign lin_tx_break_option = st.rate_select[LIN_TX_BIT];
    assign lin_rx_break_option = st.rate_select[LIN_RX_BIT];
    assign limit = rt_limit(st.rate_select);

    // ========================================
    // source clock selection
    // crystal edges become single-cycle enables, so the crystal must run
    // well below half the bus clock for no edge to be missed
    assign src_tick = rate_clock_source_select
                      ? (st.xtal_sync[1] && !st.xtal_prev)
                      : 1'b1;

    frac_prescaler i_frac_prescaler (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .run       (serial_enable),
        .src_tick  (src_tick),
        .int_code  (st.fine_prescale[INT_PRESCALE_LSB+:3]),
        .fine_code (st.fine_prescale[FINE_LSB+:5]),
        .tick      (pre_tick),
        .frame_pos (frame_pos),
        .bypass    (bypass)
    );

    assign status_word = {15'h0000, bypass, 3'h0, frame_pos,
                          st.tx_break_bits, st.rx_break_bits};

    // ========================================
    // bus handshakes
    assign awready = !st.aw_held && !st.bvalid;
    assign wready  = !st.w_held && !st.bvalid;
    assign arready = !st.rvalid;
    assign bvalid  = st.bvalid;
    assign bresp   = st.bresp;
    assign rvalid  = st.rvalid;
    assign rdata   = st.rdata;
    assign rresp   = st.rresp;

    assign sample_tick   = st.sample_tick;
    assign bit_tick      = st.bit_tick;
    assign rx_break_bits = st.rx_break_bits;
    assign tx_break_bits = st.tx_break_bits;

    // ========================================
    // next state
    always_comb begin
        next_st = st;
        next_st.sample_tick = 1'b0;
        next_st.bit_tick = 1'b0;

        // write channel: address and data may arrive in either order
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (awvalid && awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = wdata[7:0];
            next_st.w_strb0 = wstrb[0];
        end
        if (next_st.aw_held && next_st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            case (next_st.aw_addr)
                RATE_SELECT_OFFSET: begin
                    if (next_st.w_strb0) begin
                        next_st.rate_select =
                            next_st.w_data & RATE_SELECT_MASK;
                    end
                end
                FINE_PRESCALE_OFFSET: begin
                    if (next_st.w_strb0) begin
                        next_st.fine_prescale = next_st.w_data;
                    end
                end
                RATE_STATUS_OFFSET: begin
                    next_st.bresp = RESP_OKAY;
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end

        // read channel
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            case (araddr)
                RATE_SELECT_OFFSET: begin
                    next_st.rdata = {24'h00_0000, st.rate_select};
                end
                FINE_PRESCALE_OFFSET: begin
                    next_st.rdata = {24'h00_0000, st.fine_prescale};
                end
                RATE_STATUS_OFFSET: begin
                    next_st.rdata = status_word;
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end

        // crystal synchroniser
        next_st.xtal_sync = {st.xtal_sync[0], crystal_clock};
        next_st.xtal_prev = st.xtal_sync[1];

        // rate chain after the prescaler; one chain feeds rx and tx
        if (!serial_enable) begin
            next_st.rt_count = 13'h0000;
            next_st.bit_count = 4'h0;
        end else if (pre_tick) begin
            // >= recovers at once when software shrinks the divisor
            if (st.rt_count >= limit) begin
                next_st.rt_count = 13'h0000;
                next_st.sample_tick = 1'b1;
                next_st.bit_count = st.bit_count + 4'h1;
                next_st.bit_tick = (st.bit_count == SAMPLES_LAST);
            end else begin
                next_st.rt_count = st.rt_count + 13'h0001;
            end
        end

        // break lengths for the shifters
        next_st.rx_break_bits = break_bits(lin_rx_break_option,
                                           char_length_select);
        next_st.tx_break_bits = break_bits(lin_tx_break_option,
                                           char_length_select);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // helper counters for checks
    logic [13:0] pre_gap;
    logic        gap_ok;
    logic [4:0]  samp_gap;
    logic        samp_ok;
    logic        cfg_write;
    assign cfg_write = st.aw_held || (awvalid && awready);

    always_ff @(posedge aclk) begin
        if (!aresetn || !serial_enable || cfg_write) begin
            pre_gap <= '0;
            gap_ok <= 1'b0;
            samp_gap <= '0;
            samp_ok <= 1'b0;
        end else begin
            pre_gap <= (sample_tick ? 14'h0000 : pre_gap)
                       + {13'h0000, pre_tick};
            if (sample_tick) begin
                gap_ok <= 1'b1;
                samp_gap <= bit_tick ? 5'h00 : samp_gap + 5'h01;
                samp_ok <= samp_ok || bit_tick;
            end
        end
    end

    // ========================================
    // assertions
    a_rx_only_break: assert property (@(posedge aclk)
        disable iff (!aresetn)
        lin_rx_break_option && !lin_tx_break_option
        |=> rx_break_bits == ($past(char_length_select)
            ? BREAK_LIN_LONG : BREAK_LIN_SHORT))
        else $error("rx break length wrong");

    a_tx_only_break: assert property (@(posedge aclk)
        disable iff (!aresetn)
        lin_tx_break_option && !lin_rx_break_option
        |=> tx_break_bits == ($past(char_length_select)
            ? BREAK_LIN_LONG : BREAK_LIN_SHORT))
        else $error("tx break length wrong");

    a_both_lin_break: assert property (@(posedge aclk)
        disable iff (!aresetn)
        lin_tx_break_option && lin_rx_break_option
        |=> rx_break_bits == tx_break_bits
            && rx_break_bits == ($past(char_length_select)
            ? BREAK_LIN_LONG : BREAK_LIN_SHORT))
        else $error("combined lin break lengths differ");

    a_normal_break: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !lin_tx_break_option && !lin_rx_break_option
        |=> tx_break_bits == ($past(char_length_select)
            ? BREAK_NORMAL_LONG : BREAK_NORMAL_SHORT))
        else $error("normal break length wrong");

    a_sample_spacing: assert property (@(posedge aclk)
        disable iff (!aresetn)
        sample_tick && gap_ok && serial_enable
        |-> pre_gap == {1'b0, limit} + 14'h0001)
        else $error("sample tick spacing wrong");

    a_bit_spacing: assert property (@(posedge aclk)
        disable iff (!aresetn)
        bit_tick && samp_ok |-> sample_tick
            && samp_gap == {1'b0, SAMPLES_LAST})
        else $error("bit tick not every sixteenth sample");

    a_reset_clears: assert property (@(posedge aclk)
        $rose(aresetn) |-> st.rate_select == RATE_SELECT_RESET
            && st.fine_prescale == FINE_PRESCALE_RESET && bypass
            && limit == 13'(OVERSAMPLE_DIV - 1))
        else $error("reset left divider settings");

    a_xtal_gating: assert property (@(posedge aclk)
        disable iff (!aresetn)
        serial_enable && rate_clock_source_select && bypass
        && !(st.xtal_sync[1] && !st.xtal_prev)
        |=> !pre_tick)
        else $error("prescaler ran without crystal edge");

    a_bus_clock_run: assert property (@(posedge aclk)
        disable iff (!aresetn)
        serial_enable && !rate_clock_source_select && bypass
        ##1 serial_enable && bypass |-> pre_tick)
        else $error("bypassed bus clock did not tick");

    a_write_answer: assert property (@(posedge aclk)
        disable iff (!aresetn)
        awvalid && awready && wvalid && wready |=> bvalid)
        else $error("write not answered next cycle");

    c_bit_tick:  cover property (@(posedge aclk) bit_tick);
    c_xtal_tick: cover property (@(posedge aclk)
        rate_clock_source_select && sample_tick);
    c_frac_run:  cover property (@(posedge aclk)
        !bypass && st.fine_prescale[FINE_LSB+:5] != 5'h00 && sample_tick);
    c_lin_both:  cover property (@(posedge aclk)
        lin_tx_break_option && lin_rx_break_option);
endmodule
`default_nettype wire

// [bench/lin_node_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lin_node_model (
    input  wire logic        aclk,
    input  wire logic        sample_tick,
    input  wire logic        bit_tick,
    output logic             crystal_clock,
    output logic [15:0]      bit_period,
    output logic [4:0]       samples_per_bit,
    output logic [15:0]      bit_count
);
    // ========================================
    // crystal source, 8 aclk per period, free running
    // offset phase keeps edges away from aclk edges
    initial begin
        crystal_clock = 1'b0;
        #7;
        forever #160 crystal_clock = ~crystal_clock;
    end

    // ========================================
    // far node times one bit as both directions see it
    logic [15:0] cyc;
    logic [4:0]  scount;
    initial begin
        cyc = 16'h0000;
        scount = 5'h00;
        bit_period = 16'h0000;
        samples_per_bit = 5'h00;
        bit_count = 16'h0000;
    end
    always @(posedge aclk) begin
        if (bit_tick) begin
            bit_period <= cyc;
            samples_per_bit <= scount + 5'(sample_tick);
            bit_count <= bit_count + 16'h0001;
            cyc <= 16'h0001;
            scount <= 5'h00;
        end else begin
            cyc <= cyc + 16'h0001;
            scount <= scount + 5'(sample_tick);
        end
    end
endmodule
`default_nettype wire

// [bench/lin_baud_rate_generator_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lin_baud_rate_generator_tb;
    import baud_gen_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, crystal_clock;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic src_sel = 1'b0, serial_enable = 1'b0, char_len = 1'b0;
    logic sample_tick, bit_tick;
    logic [3:0] rx_bits, tx_bits;
    logic [15:0] bit_period, bit_count;
    logic [4:0] samples;
    int errors = 0, tests_run = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [3:0] erx, etx;

    always #20 aclk = ~aclk;

    lin_baud_rate_generator i_lin_baud_rate_generator (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .crystal_clock(crystal_clock),
        .rate_clock_source_select(src_sel), .serial_enable(serial_enable),
        .char_length_select(char_len), .sample_tick(sample_tick),
        .bit_tick(bit_tick), .rx_break_bits(rx_bits),
        .tx_break_bits(tx_bits));

    lin_node_model i_lin_node_model (
        .aclk(aclk), .sample_tick(sample_tick), .bit_tick(bit_tick),
        .crystal_clock(crystal_clock), .bit_period(bit_period),
        .samples_per_bit(samples), .bit_count(bit_count));

    // ========================================
    // checks and bus tasks
    task automatic chk(input logic [31:0] got, exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= 4'hF;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // restart the chain around each change: bypass switch is not clean
    task automatic meas(input logic [7:0] r, f, input logic s, input int e);
        logic [15:0] b0;
        serial_enable <= 1'b0;
        wr(RATE_SELECT_OFFSET, {24'h0000_00, r});
        wr(FINE_PRESCALE_OFFSET, {24'h0000_00, f});
        src_sel <= s;
        serial_enable <= 1'b1;
        @(posedge aclk);
        b0 = bit_count;
        while (bit_count !== b0 + 16'h0002) begin
            @(posedge aclk);
        end
        chk(32'(bit_period), 32'(e), "bit period");
        chk(32'(samples), 32'h0000_0010, "samples per bit");
    endtask

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge aclk);
        errors++;
        results();
    end

    // ========================================
    // tests
    logic [7:0] rs_t [7] = '{8'h00, 8'h11, 8'h30, 8'h20, 8'h00, 8'h07,
                             8'h00};
    logic [7:0] fp_t [7] = '{8'h1F, 8'h00, 8'h00, 8'hE0, 8'h25, 8'h00,
                             8'hFF};
    int ex_t [7] = '{64, 384, 832, 2048, 138, 8192, 574};

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(RATE_SELECT_OFFSET);
        chk(rd, 32'h0000_0000, "rate_select reset");
        rdr(FINE_PRESCALE_OFFSET);
        chk(rd, 32'h0000_0000, "fine_prescale reset");
        rdr(RATE_STATUS_OFFSET);
        chk(rd & 32'h0001_00FF, 32'h0001_00AA, "status reset");
        $display("test reset done");

        for (int i = 0; i < 8; i++) begin
            char_len <= i[0];
            wr(RATE_SELECT_OFFSET, {24'h0000_00, i[2], i[1], 6'h00});
            erx = i[1] ? (i[0] ? 4'hC : 4'hB) : (i[0] ? 4'hB : 4'hA);
            etx = i[2] ? (i[0] ? 4'hC : 4'hB) : (i[0] ? 4'hB : 4'hA);
            rdr(RATE_STATUS_OFFSET);
            chk({24'h0000_00, rd[7:0]}, {24'h0000_00, etx, erx},
                "status break bits");
            chk({24'h0000_00, tx_bits, rx_bits}, {24'h0000_00, etx, erx},
                "break bit ports");
        end
        $display("test break lengths done");

        wr(RATE_SELECT_OFFSET, 32'h0000_00FF);
        chk(32'(rs), 32'(RESP_OKAY), "write resp");
        rdr(RATE_SELECT_OFFSET);
        chk(rd, {24'h0000_00, RATE_SELECT_MASK}, "reserved bit");
        wr(8'h0C, 32'h0000_0055);
        chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
        rdr(8'h0C);
        chk({rd[29:0], rs}, {30'h0, RESP_SLVERR}, "unmapped read");
        wr(RATE_STATUS_OFFSET, 32'h0000_0000);
        chk(32'(rs), 32'(RESP_OKAY), "status write resp");
        wr(FINE_PRESCALE_OFFSET, 32'h0000_00A5);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdr(FINE_PRESCALE_OFFSET);
        chk(rd, 32'h0000_0000, "fine_prescale after reset");
        rdr(RATE_SELECT_OFFSET);
        chk(rd, 32'h0000_0000, "rate_select after reset");
        $display("test registers done");

        for (int i = 0; i < 7; i++) begin
            meas(rs_t[i], fp_t[i], 1'b0, ex_t[i]);
        end
        $display("test bus clock rates done");
        meas(8'h00, 8'h00, 1'b1, 512);
        $display("test crystal source done");
        results();
    end
endmodule
`default_nettype wire
